// >>> design/spra_rom_dev.sv
// Phrase ROM device end: address load, serial read-out, indirect addressing
// Notes on behaviour
// - Decode four two-bit instruction codes exactly.
// - Five address loads, one nibble each.
// - First read after load: data in 24 cycles.
// - Each read shifts out one further bit.
// - Counter advances once per eight reads.
// - Controller loads address before indirect addressing.
// - Indirect reads two bytes into the counter.
// - Low byte, then six bits above it.
// - Indirect: data ready 74 cycles later.
// - Sixteen devices; chip select picks one.
// - Each device holds 16K bytes.
// - Counter is fourteen-bit plain binary.
// - Eight-bit register holds byte being shifted.
// - Pin floats on overflow or deselect.
// - Clear input resets state, silences pin.
`timescale 1ns/1ps
`default_nettype none
module spra_rom_dev #(
    parameter logic [spra_pkg::CS_W-1:0] CHIP_ID = 4'h0
) (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic arst_n_i,
    // Link to controller
    spra_link_if.dev link,
    // Status
    output logic dev_sel_o,
    output logic dev_ovf_o,
    output logic dev_busy_o
);
    typedef enum logic [1:0] {
        DS_IDLE = 2'h0,
        DS_WAIT = 2'h1,
        DS_DATA = 2'h3
    } spra_dstate_t;

    ////////////////////////////////////////////////////////////////////////////
    // State
    spra_dstate_t state_q;
    spra_dstate_t state_d;
    logic [spra_pkg::LOAD_W-1:0] load_q;
    logic [spra_pkg::LOAD_W-1:0] load_d;
    logic pend_q;
    logic pend_d;
    logic [spra_pkg::ADDR_W-1:0] addr_q;
    logic [spra_pkg::ADDR_W-1:0] addr_d;
    logic [spra_pkg::CS_W-1:0] cs_q;
    logic [spra_pkg::CS_W-1:0] cs_d;
    logic ovf_q;
    logic ovf_d;
    logic [spra_pkg::BYTE_W-1:0] data_q;
    logic [spra_pkg::BYTE_W-1:0] data_d;
    logic [spra_pkg::BIT_W-1:0] bit_q;
    logic [spra_pkg::BIT_W-1:0] bit_d;
    logic [spra_pkg::WAIT_W-1:0] wait_q;
    logic [spra_pkg::WAIT_W-1:0] wait_d;

    ////////////////////////////////////////////////////////////////////////////
    // Decode
    spra_pkg::spra_instr_t code;
    logic clear;
    logic [spra_pkg::NIB_W-1:0] nibble_in;
    logic [spra_pkg::ADDR_W-1:0] load_addr;
    logic [spra_pkg::CS_W-1:0] load_cs;
    logic [spra_pkg::ADDR_W-1:0] base_addr;
    logic [spra_pkg::CS_W-1:0] base_cs;
    logic [spra_pkg::ADDR_W-1:0] base_next;
    logic [spra_pkg::BYTE_W-1:0] ind_lo;
    logic [spra_pkg::BYTE_W-1:0] ind_hi;
    logic [spra_pkg::ADDR_W-1:0] ind_addr;
    logic [spra_pkg::ADDR_W:0] addr_inc;
    logic [spra_pkg::BYTE_W-1:0] cur_byte;
    logic [spra_pkg::BYTE_W-1:0] next_byte;
    logic sel;

    assign code = spra_pkg::spra_instr_t'({link.instr_code_bit_hi, link.instr_code_bit_lo});
    assign clear = link.pwr_clear;

    // Pin supplies bit 3, the three address inputs bits 2..0
    assign nibble_in = {link.shared_addr_serial_pin, link.addr_nibble_in};

    // First nibble lands lowest; bits 17..14 of the load form the select
    assign load_addr = load_q[spra_pkg::ADDR_W-1:0];
    assign load_cs = load_q[spra_pkg::FULL_ADDR_W-1:spra_pkg::ADDR_W];

    // Indirect works from a freshly loaded address if one is pending
    assign base_addr = pend_q ? load_addr : addr_q;
    assign base_cs = pend_q ? load_cs : cs_q;
    assign base_next = base_addr + 14'h0001;
    assign ind_lo = spra_pkg::spra_rom_byte(base_cs, base_addr);
    assign ind_hi = spra_pkg::spra_rom_byte(base_cs, base_next);
    assign ind_addr = {ind_hi[spra_pkg::IND_HI_W-1:0], ind_lo};

    // Extra bit catches the wrap out of the 16K space
    assign addr_inc = {1'h0, addr_q} + 15'h0001;
    assign cur_byte = spra_pkg::spra_rom_byte(cs_q, addr_q);
    assign next_byte = spra_pkg::spra_rom_byte(cs_q, addr_inc[spra_pkg::ADDR_W-1:0]);

    assign sel = (cs_q == CHIP_ID);

    ////////////////////////////////////////////////////////////////////////////
    // Pin drive
    assign link.dev_pin_o = data_q[0];
    // Combinational release on an address step keeps the first nibble clean
    assign link.dev_pin_oe = (state_q == DS_DATA) && sel && !ovf_q
        && !clear
        && (code != spra_pkg::SPRA_ADDR);

    assign dev_sel_o = sel;
    assign dev_ovf_o = ovf_q;
    assign dev_busy_o = (state_q == DS_WAIT);

    ////////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        state_d = state_q;
        load_d = load_q;
        pend_d = pend_q;
        addr_d = addr_q;
        cs_d = cs_q;
        ovf_d = ovf_q;
        data_d = data_q;
        bit_d = bit_q;
        wait_d = wait_q;
        if (clear) begin
            state_d = DS_IDLE;
            load_d = spra_pkg::LOAD_RST;
            pend_d = 1'h0;
            addr_d = spra_pkg::ADDR_RST;
            cs_d = spra_pkg::CS_RST;
            ovf_d = 1'h0;
            data_d = spra_pkg::BYTE_RST;
            bit_d = spra_pkg::BIT_RST;
            wait_d = spra_pkg::WAIT_RST;
        end else if (state_q == DS_WAIT) begin
            // Instructions during the access time are ignored
            wait_d = wait_q - 7'h01;
            if (wait_q == spra_pkg::WAIT_ONE) begin
                data_d = cur_byte;
                bit_d = spra_pkg::BIT_RST;
                state_d = DS_DATA;
            end
        end else begin
            unique case (code)
                spra_pkg::SPRA_ADDR: begin
                    load_d = {nibble_in, load_q[spra_pkg::LOAD_W-1:spra_pkg::NIB_W]};
                    pend_d = 1'h1;
                    state_d = DS_IDLE;
                end
                spra_pkg::SPRA_READ: begin
                    if (pend_q) begin
                        addr_d = load_addr;
                        cs_d = load_cs;
                        ovf_d = 1'h0;
                        pend_d = 1'h0;
                        wait_d = spra_pkg::DIRECT_WAIT;
                        state_d = DS_WAIT;
                    end else if (state_q == DS_DATA) begin
                        if (bit_q == spra_pkg::BIT_LAST) begin
                            addr_d = addr_inc[spra_pkg::ADDR_W-1:0];
                            ovf_d = ovf_q | addr_inc[spra_pkg::ADDR_W];
                            data_d = next_byte;
                            bit_d = spra_pkg::BIT_RST;
                        end else begin
                            data_d = {1'h0, data_q[spra_pkg::BYTE_W-1:1]};
                            bit_d = bit_q + 3'h1;
                        end
                    end
                end
                spra_pkg::SPRA_IND: begin
                    // Relies on a prior five-step load or a live counter
                    addr_d = ind_addr;
                    cs_d = base_cs;
                    ovf_d = 1'h0;
                    pend_d = 1'h0;
                    wait_d = spra_pkg::INDIRECT_WAIT;
                    state_d = DS_WAIT;
                end
                spra_pkg::SPRA_NOP: begin
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_q <= DS_IDLE;
            load_q <= spra_pkg::LOAD_RST;
            pend_q <= 1'h0;
            addr_q <= spra_pkg::ADDR_RST;
            cs_q <= spra_pkg::CS_RST;
            ovf_q <= 1'h0;
            data_q <= spra_pkg::BYTE_RST;
            bit_q <= spra_pkg::BIT_RST;
            wait_q <= spra_pkg::WAIT_RST;
        end else begin
            state_q <= state_d;
            load_q <= load_d;
            pend_q <= pend_d;
            addr_q <= addr_d;
            cs_q <= cs_d;
            ovf_q <= ovf_d;
            data_q <= data_d;
            bit_q <= bit_d;
            wait_q <= wait_d;
        end
    end
endmodule
`default_nettype wire

// >>> common/spra_pkg.sv
// Shared constants, codes and mask pattern of the serial phrase ROM link
package spra_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Widths
    localparam int ADDR_W = 14;
    localparam int CS_W = 4;
    localparam int FULL_ADDR_W = 18;
    localparam int NIB_W = 4;
    localparam int NIB_STEPS = 5;
    localparam int LOAD_W = 20;
    localparam int BYTE_W = 8;
    localparam int BIT_W = 3;
    localparam int WAIT_W = 7;
    localparam int IND_HI_W = 6;
    localparam int NIB_CNT_W = 3;

    ////////////////////////////////////////////////////////////////////////////
    // Latencies in clock cycles
    localparam int DIRECT_CYC = 24;
    localparam int INDIRECT_CYC = 74;
    localparam logic [WAIT_W-1:0] DIRECT_WAIT = WAIT_W'(DIRECT_CYC);
    localparam logic [WAIT_W-1:0] INDIRECT_WAIT = WAIT_W'(INDIRECT_CYC);
    localparam logic [WAIT_W-1:0] WAIT_ONE = 7'h01;
    localparam logic [WAIT_W-1:0] WAIT_RST = 7'h00;

    ////////////////////////////////////////////////////////////////////////////
    // Reset values and counter limits
    localparam logic [ADDR_W-1:0] ADDR_RST = 14'h0000;
    localparam logic [CS_W-1:0] CS_RST = 4'h0;
    localparam logic [LOAD_W-1:0] LOAD_RST = 20'h00000;
    localparam logic [BYTE_W-1:0] BYTE_RST = 8'h00;
    localparam logic [BIT_W-1:0] BIT_RST = 3'h0;
    localparam logic [BIT_W-1:0] BIT_LAST = 3'h7;
    localparam logic [NIB_CNT_W-1:0] NIB_RST = 3'h0;
    localparam logic [NIB_CNT_W-1:0] NIB_LAST = 3'h4;

    ////////////////////////////////////////////////////////////////////////////
    // Instruction codes, written as {hi, lo}
    typedef enum logic [1:0] {
        SPRA_NOP = 2'h0,
        SPRA_READ = 2'h1,
        SPRA_ADDR = 2'h2,
        SPRA_IND = 2'h3
    } spra_instr_t;

    // Mask contents; the pattern stands in for the customer's masked data
    function automatic logic [BYTE_W-1:0] spra_rom_byte(
        input logic [CS_W-1:0] cs,
        input logic [ADDR_W-1:0] addr
    );
        logic [BYTE_W-1:0] mix;
        mix = addr[7:0] ^ {addr[13:8], 2'h0};
        return mix ^ {cs, cs} ^ 8'h5A;
    endfunction

endpackage

// >>> common/spra_link_if.sv
// Link between phrase ROM controller and phrase ROM device
`timescale 1ns/1ps
`default_nettype none
interface spra_link_if;
    logic instr_code_bit_hi;
    logic instr_code_bit_lo;
    logic [spra_pkg::NIB_W-2:0] addr_nibble_in;
    logic pwr_clear;
    logic ctl_pin_o;
    logic ctl_pin_oe;
    logic dev_pin_o;
    logic dev_pin_oe;
    logic shared_addr_serial_pin;

    // Device wins a clash; a floating pin reads low as if pulled down
    assign shared_addr_serial_pin = dev_pin_oe ? dev_pin_o : (ctl_pin_oe ? ctl_pin_o : 1'h0);

    modport dev (
        input instr_code_bit_hi,
        input instr_code_bit_lo,
        input addr_nibble_in,
        input pwr_clear,
        input shared_addr_serial_pin,
        output dev_pin_o,
        output dev_pin_oe
    );

    modport ctl (
        output instr_code_bit_hi,
        output instr_code_bit_lo,
        output addr_nibble_in,
        output pwr_clear,
        output ctl_pin_o,
        output ctl_pin_oe,
        input shared_addr_serial_pin
    );
endinterface
`default_nettype wire

// >>> design/spra_buf2.sv
// Two-entry valid/ready buffer
`timescale 1ns/1ps
`default_nettype none
module spra_buf2 #(
    parameter int W = 8,
    parameter int DEPTH = 2
) (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic arst_n_i,
    // Fill side
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [W-1:0] in_data_i,
    // Drain side
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [W-1:0] out_data_o
);
    localparam int PTR_W = $clog2(DEPTH);

    function automatic logic [PTR_W-1:0] next_ptr(input logic [PTR_W-1:0] p);
        return (p == PTR_W'(DEPTH - 1)) ? '0 : p + PTR_W'(1);
    endfunction

    logic [W-1:0] mem_q [DEPTH];
    logic [PTR_W-1:0] wr_q;
    logic [PTR_W-1:0] rd_q;
    logic [PTR_W:0] cnt_q;
    logic push;
    logic pop;

    ////////////////////////////////////////////////////////////////////////////
    assign in_ready_o = (cnt_q != (PTR_W+1)'(DEPTH));
    assign out_valid_o = (cnt_q != '0);
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;
    assign out_data_o = mem_q[rd_q];

    always_ff @(posedge core_clk_i) begin
        if (push) begin
            mem_q[wr_q] <= in_data_i;
        end
    end

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_q <= next_ptr(wr_q);
            end
            if (pop) begin
                rd_q <= next_ptr(rd_q);
            end
            cnt_q <= cnt_q + (PTR_W+1)'(push) - (PTR_W+1)'(pop);
        end
    end
endmodule
`default_nettype wire

// >>> design/spra_ctrl.sv
// Controller end: loads address, reads bytes serially into a buffer
`timescale 1ns/1ps
`default_nettype none
module spra_ctrl (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic arst_n_i,
    // Link to device
    spra_link_if.ctl link,
    // Commands
    input wire logic [spra_pkg::FULL_ADDR_W-1:0] cmd_addr_i,
    input wire logic cmd_direct_i,
    input wire logic cmd_indirect_i,
    input wire logic cmd_stop_i,
    input wire logic clear_req_i,
    output logic cmd_ready_o,
    output logic busy_o,
    // Byte stream
    output logic byte_valid_o,
    input wire logic byte_ready_i,
    output logic [spra_pkg::BYTE_W-1:0] byte_data_o
);
    typedef enum logic [2:0] {
        CS_IDLE = 3'h0,
        CS_LOAD = 3'h1,
        CS_ISSUE = 3'h3,
        CS_WAIT = 3'h2,
        CS_SHIFT = 3'h6
    } spra_cstate_t;

    spra_cstate_t state_q;
    logic [spra_pkg::LOAD_W-1:0] addr_q;
    logic [spra_pkg::NIB_CNT_W-1:0] nib_q;
    logic ind_q;
    logic clear_q;
    logic [spra_pkg::WAIT_W-1:0] wait_q;
    logic [spra_pkg::BIT_W-1:0] bit_q;
    logic [spra_pkg::BYTE_W-1:0] shreg_q;
    spra_pkg::spra_instr_t code;
    logic step_read;
    logic last_bit;
    logic buf_ready;
    logic [spra_pkg::BYTE_W-1:0] byte_in;

    ////////////////////////////////////////////////////////////////////////////
    // Link drive
    assign last_bit = (bit_q == spra_pkg::BIT_LAST);
    // Holding reads when the buffer is full stalls the device's stream
    assign step_read = (state_q == CS_SHIFT) && (!last_bit || buf_ready);
    assign code = (state_q == CS_LOAD) ? spra_pkg::SPRA_ADDR :
        (state_q == CS_ISSUE) ? (ind_q ? spra_pkg::SPRA_IND : spra_pkg::SPRA_READ) :
        step_read ? spra_pkg::SPRA_READ : spra_pkg::SPRA_NOP;
    assign {link.instr_code_bit_hi, link.instr_code_bit_lo} = code;
    assign link.addr_nibble_in = addr_q[spra_pkg::NIB_W-2:0];
    assign link.ctl_pin_o = addr_q[spra_pkg::NIB_W-1];
    assign link.ctl_pin_oe = (state_q == CS_LOAD);
    assign link.pwr_clear = clear_q;
    assign byte_in = {link.shared_addr_serial_pin, shreg_q[spra_pkg::BYTE_W-1:1]};
    assign cmd_ready_o = (state_q == CS_IDLE) && !clear_q;
    assign busy_o = (state_q != CS_IDLE);

    spra_buf2 #(
        .W(spra_pkg::BYTE_W),
        .DEPTH(2)
    ) spra_buf2_inst (
        .core_clk_i(core_clk_i),
        .arst_n_i(arst_n_i),
        .in_valid_i(step_read && last_bit),
        .in_ready_o(buf_ready),
        .in_data_i(byte_in),
        .out_valid_o(byte_valid_o),
        .out_ready_i(byte_ready_i),
        .out_data_o(byte_data_o)
    );

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_q <= CS_IDLE;
            addr_q <= spra_pkg::LOAD_RST;
            nib_q <= spra_pkg::NIB_RST;
            ind_q <= 1'h0;
            clear_q <= 1'h0;
            wait_q <= spra_pkg::WAIT_RST;
            bit_q <= spra_pkg::BIT_RST;
            shreg_q <= spra_pkg::BYTE_RST;
        end else begin
            clear_q <= clear_req_i;
            if (clear_req_i || clear_q) begin
                state_q <= CS_IDLE;
                bit_q <= spra_pkg::BIT_RST;
            end else begin
                unique case (state_q)
                    CS_IDLE: begin
                        if (cmd_direct_i || cmd_indirect_i) begin
                            addr_q <= {2'h0, cmd_addr_i};
                            ind_q <= cmd_indirect_i && !cmd_direct_i;
                            nib_q <= spra_pkg::NIB_RST;
                            state_q <= CS_LOAD;
                        end
                    end
                    CS_LOAD: begin
                        // Low nibble first, the fourth and fifth carry the select
                        addr_q <= {4'h0, addr_q[spra_pkg::LOAD_W-1:spra_pkg::NIB_W]};
                        nib_q <= nib_q + 3'h1;
                        if (nib_q == spra_pkg::NIB_LAST) begin
                            state_q <= CS_ISSUE;
                        end
                    end
                    CS_ISSUE: begin
                        wait_q <= ind_q ? spra_pkg::INDIRECT_WAIT : spra_pkg::DIRECT_WAIT;
                        bit_q <= spra_pkg::BIT_RST;
                        state_q <= CS_WAIT;
                    end
                    CS_WAIT: begin
                        wait_q <= wait_q - 7'h01;
                        if (wait_q == spra_pkg::WAIT_ONE) begin
                            state_q <= CS_SHIFT;
                        end
                    end
                    CS_SHIFT: begin
                        // A stop drops any partly gathered byte
                        if (cmd_stop_i) begin
                            state_q <= CS_IDLE;
                            bit_q <= spra_pkg::BIT_RST;
                        end else if (step_read) begin
                            shreg_q <= byte_in;
                            bit_q <= bit_q + 3'h1;
                        end
                    end
                    default: begin
                        state_q <= CS_IDLE;
                    end
                endcase
            end
        end
    end
endmodule
`default_nettype wire

// >>> sim/spra_link_asserts.sv
// Concurrent checks on the phrase ROM link signals
`timescale 1ns/1ps
`default_nettype none
module spra_link_asserts (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic arst_n_i,
    // Link signals
    input wire logic instr_code_bit_hi,
    input wire logic instr_code_bit_lo,
    input wire logic [spra_pkg::NIB_W-2:0] addr_nibble_in,
    input wire logic pwr_clear,
    input wire logic ctl_pin_o,
    input wire logic ctl_pin_oe,
    input wire logic dev_pin_o,
    input wire logic dev_pin_oe,
    input wire logic shared_addr_serial_pin
);
    ////////////////////////////////////////////////////////////////////////////
    // Cycles since the last access start; saturates so stale counts never match
    wire logic [1:0] code;
    wire logic start_dir;
    wire logic start_ind;
    wire logic [6:0] since_d;
    wire logic ind_d;
    logic [1:0] last_q;
    logic [6:0] since_q;
    logic ind_q;
    assign code = {instr_code_bit_hi, instr_code_bit_lo};
    assign start_dir = (code == spra_pkg::SPRA_READ) && (last_q == spra_pkg::SPRA_ADDR);
    assign start_ind = (code == spra_pkg::SPRA_IND);
    assign since_d = pwr_clear ? 7'h7F : (start_dir || start_ind) ? 7'h01 :
                     (since_q == 7'h7F) ? since_q : since_q + 7'h01;
    assign ind_d = start_ind ? 1'b1 : (start_dir ? 1'b0 : ind_q);
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            last_q <= 2'h0;
            since_q <= 7'h7F;
            ind_q <= 1'b0;
        end else begin
            last_q <= code;
            since_q <= since_d;
            ind_q <= ind_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!arst_n_i);

    a_clear_pin_quiet: assert property (pwr_clear |-> !dev_pin_oe)
        else $error("device drives pin during clear");
    a_load_pin_input: assert property (code == spra_pkg::SPRA_ADDR |-> !dev_pin_oe)
        else $error("device drives pin during address load");
    a_ctl_drive_load: assert property (ctl_pin_oe == (code == spra_pkg::SPRA_ADDR))
        else $error("controller pin drive not tied to address load");
    a_five_nibbles: assert property ($rose(code == spra_pkg::SPRA_ADDR) |->
        (code == spra_pkg::SPRA_ADDR)[*5] ##1 (code != spra_pkg::SPRA_ADDR))
        else $error("address load is not five steps");
    a_direct_wait: assert property (!ind_q && since_q >= 7'h01 && since_q <= 7'h18 |-> !dev_pin_oe)
        else $error("direct data appears early");
    a_indirect_wait: assert property (ind_q && since_q inside {[7'h01:7'h4A]} |-> !dev_pin_oe)
        else $error("indirect data appears early");
    a_data_on_time: assert property ($rose(dev_pin_oe) && since_q < 7'h60 |->
        since_q == (ind_q ? 7'h4B : 7'h19))
        else $error("data appears late");
    a_bit_holds: assert property (dev_pin_oe && $past(dev_pin_oe) &&
        $past(code) != spra_pkg::SPRA_READ |-> $stable(dev_pin_o))
        else $error("serial bit changed without read");
    a_ind_after_load: assert property (code == spra_pkg::SPRA_IND |-> last_q == spra_pkg::SPRA_ADDR)
        else $error("indirect issued without a fresh address load");
    a_pin_from_ctl: assert property (code == spra_pkg::SPRA_ADDR |->
        shared_addr_serial_pin == ctl_pin_o)
        else $error("nibble bit 3 not taken from controller during load");
endmodule
`default_nettype wire

// >>> sim/serial_phrase_rom_access_tb.sv
// Testbench joining phrase ROM controller and device across the link
`timescale 1ns/1ps
`default_nettype none
module serial_phrase_rom_access_tb;
    logic core_clk_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic [17:0] cmd_addr_i = 18'h00000;
    logic cmd_direct_i = 1'b0;
    logic cmd_indirect_i = 1'b0;
    logic cmd_stop_i = 1'b0;
    logic clear_req_i = 1'b0;
    logic byte_ready_i = 1'b0;
    logic cmd_ready_o, busy_o, byte_valid_o, dev_sel_o, dev_ovf_o, dev_busy_o;
    logic [7:0] byte_data_o;
    logic [7:0] exp_q[$];
    int num_errors = 0;
    int cmp_count = 0;
    int seen = 0;
    int stall = 0;
    int i;
    integer seed = 58;

    always #2 core_clk_i = ~core_clk_i;

    ////////////////////////////////////////////////////////////////////////////
    spra_link_if link_if();
    spra_ctrl spra_ctrl_inst (.core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .link(link_if),
        .cmd_addr_i(cmd_addr_i), .cmd_direct_i(cmd_direct_i), .cmd_indirect_i(cmd_indirect_i),
        .cmd_stop_i(cmd_stop_i), .clear_req_i(clear_req_i), .cmd_ready_o(cmd_ready_o),
        .busy_o(busy_o), .byte_valid_o(byte_valid_o), .byte_ready_i(byte_ready_i),
        .byte_data_o(byte_data_o));
    spra_rom_dev #(.CHIP_ID(4'h0)) spra_rom_dev_inst (.core_clk_i(core_clk_i),
        .arst_n_i(arst_n_i), .link(link_if), .dev_sel_o(dev_sel_o), .dev_ovf_o(dev_ovf_o),
        .dev_busy_o(dev_busy_o));
    spra_link_asserts spra_link_asserts_inst (.core_clk_i(core_clk_i), .arst_n_i(arst_n_i),
        .instr_code_bit_hi(link_if.instr_code_bit_hi),
        .instr_code_bit_lo(link_if.instr_code_bit_lo),
        .addr_nibble_in(link_if.addr_nibble_in), .pwr_clear(link_if.pwr_clear),
        .ctl_pin_o(link_if.ctl_pin_o), .ctl_pin_oe(link_if.ctl_pin_oe),
        .dev_pin_o(link_if.dev_pin_o), .dev_pin_oe(link_if.dev_pin_oe),
        .shared_addr_serial_pin(link_if.shared_addr_serial_pin));

    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input string nm, input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // Floating pin reads low, so a deselected or overflowed byte is all zero
    function automatic logic [7:0] ref_byte(input logic [3:0] cs, input int adr);
        logic [13:0] w;
        w = adr[13:0];
        if (cs != 4'h0 || adr > 32'h3FFF) return 8'h00;
        return w[7:0] ^ {w[13:8], 2'h0} ^ 8'h5A;
    endfunction

    task automatic run(input logic [17:0] a, input logic ind, input int n);
        int k;
        int p;
        logic [7:0] lo, hi;
        exp_q.delete();
        seen = 0;
        lo = ref_byte(a[17:14], a[13:0]);
        hi = ref_byte(a[17:14], a[13:0] + 1);
        p = ind ? {18'h00000, hi[5:0], lo} : a[13:0];
        // Extra notes cover bytes fetched before the stop lands
        for (k = 0; k < n + 4; k++) exp_q.push_back(ref_byte(a[17:14], p + k));
        @(negedge core_clk_i);
        cmd_addr_i = a;
        cmd_direct_i = !ind;
        cmd_indirect_i = ind;
        @(negedge core_clk_i);
        cmd_direct_i = 1'b0;
        cmd_indirect_i = 1'b0;
        for (k = 0; k < 4000 && seen < n; k++) @(negedge core_clk_i);
        cmd_stop_i = 1'b1;
        for (k = 0; k < 100 && busy_o !== 1'b0; k++) @(negedge core_clk_i);
        cmd_stop_i = 1'b0;
        repeat (40) @(negedge core_clk_i);
        check("idle", {7'h00, busy_o}, 8'h00);
        check("count", 8'(seen >= n), 8'h01);
    endtask

    task automatic summarize();
        $display("Comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    always @(negedge core_clk_i) begin
        byte_ready_i = (stall == 0) && (($random(seed) & 32'h1) != 0);
        if (stall > 0) stall = stall - 1;
    end

    always @(posedge core_clk_i) begin
        if (arst_n_i && byte_valid_o === 1'b1 && byte_ready_i === 1'b1) begin
            check("byte", byte_data_o, exp_q.size() > 0 ? exp_q.pop_front() : 8'hXX);
            seen++;
        end
    end

    initial begin
        #120000;
        num_errors++;
        summarize();
    end

    initial begin
        repeat (2) @(negedge core_clk_i);
        arst_n_i = 1'b1;
        check("ready", {7'h00, cmd_ready_o}, 8'h01);
        check("pin_oe", {7'h00, link_if.dev_pin_oe}, 8'h00);
        for (i = 0; i < 3; i++) run({4'h0, 14'($random(seed))}, 1'b0, 3);
        @(posedge core_clk_i);
        stall = 90;
        run(18'h01234, 1'b0, 5);
        run(18'h03FFE, 1'b0, 3);
        check("ovf", {7'h00, dev_ovf_o}, 8'h01);
        run(18'h2C010, 1'b0, 2);
        check("sel", {7'h00, dev_sel_o}, 8'h00);
        for (i = 0; i < 2; i++) run({4'h0, 14'($random(seed)) & 14'h3FF0}, 1'b1, 3);
        run(18'h00200, 1'b1, 2);
        // Clear during the access wait: nothing may come out afterwards
        exp_q.delete();
        @(negedge core_clk_i);
        cmd_direct_i = 1'b1;
        @(negedge core_clk_i);
        cmd_direct_i = 1'b0;
        repeat (12) @(negedge core_clk_i);
        check("dev_busy", {7'h00, dev_busy_o}, 8'h01);
        clear_req_i = 1'b1;
        repeat (3) @(negedge core_clk_i);
        check("busy", {7'h00, busy_o}, 8'h00);
        check("dev_idle", {7'h00, dev_busy_o}, 8'h00);
        check("clr_oe", {7'h00, link_if.dev_pin_oe}, 8'h00);
        clear_req_i = 1'b0;
        repeat (60) @(negedge core_clk_i);
        check("ready", {7'h00, cmd_ready_o}, 8'h01);
        run(18'h00040, 1'b0, 3);
        summarize();
    end
endmodule
`default_nettype wire
